// [core/rqs_pkg.sv]
// Package: register map, field positions and carriers for the requantizer/sync control bank
package rqs_pkg;
	localparam int          RQS_ADDR_W         = 8;
	localparam int          RQS_NCHAN          = 4;
	localparam logic [7:0]  RQS_ADDR_CHAN_IDX  = 8'h05;
	localparam logic [7:0]  RQS_ADDR_SYNC      = 8'h3a;
	localparam logic [7:0]  RQS_ADDR_CTRL      = 8'h3c;
	localparam logic [7:0]  RQS_ADDR_TUNE      = 8'h3e;
	localparam logic [7:0]  RQS_RST_SYNC       = 8'h00;
	localparam logic [7:0]  RQS_RST_CTRL       = 8'h00;
	localparam logic [7:0]  RQS_RST_TUNE       = 8'h1c;
	localparam logic [3:0]  RQS_RST_CHAN_IDX   = 4'hf;
	localparam int          RQS_SYNC_MASTER_B  = 0;
	localparam int          RQS_SYNC_DIV_EN_B  = 1;
	localparam int          RQS_SYNC_ONESHOT_B = 2;
	localparam int          RQS_CTRL_EN_B      = 0;
	localparam int          RQS_CTRL_PINDIS_B  = 4;
	localparam logic [2:0]  RQS_BAND_WIDTH_22  = 3'h0;
	localparam logic [2:0]  RQS_BAND_WIDTH_33  = 3'h1;
	localparam logic [2:0]  RQS_BAND_WIDTH_36  = 3'h2;
	localparam logic [7:0]  RQS_SYNC_MASK      = 8'h07;
	localparam logic [7:0]  RQS_CTRL_MASK      = 8'h1f;
	localparam logic [7:0]  RQS_TUNE_MASK      = 8'h3f;

	// Register write request from the serial port decoder
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} rqs_wr_t;

	// Per-channel requantizer settings handed to the datapath
	typedef struct packed {
		logic       enable;
		logic [2:0] band_width;
		logic [5:0] tuning;
	} rqs_chan_t;
endpackage

// [core/rqs_regs.sv]
// Sync and noise shaping requantizer control register bank
`timescale 1ns/1ns
// Function
// - Mode bit clear: every qualifying sync rising edge resets the divider.
// - Mode bit set: only the next qualifying sync rising edge resets the divider.
// - One-shot mode ignores sync edges after the first accepted one until the sync register is written again.
// - Sync reaches the divider only with divider enable and master enable both set.
// - All sync functions stay inactive while master enable is low.
// - Pin disable bit 0 uses the external pin; 1 ignores it.
// - Per-channel writes land only on channels chosen by the index register.
// - Bandwidth field 000, 001, 010 selects 22, 33, 36 percent modes.
// - Register enable bit high enables requantizer, low bypasses it.
// - Register enable bit only matters when pin disable bit is set.
// - Six-bit tuning word sets the enhanced band edges.
// - Each tuning step moves band edges by half a percent of sample rate.
module rqs_regs
	import rqs_pkg::*;
#(
	parameter int NCHAN = RQS_NCHAN
)
(
	// Clock and reset
	input  wire logic                    MCLK,
	input  wire logic                    RST_N,
	// Register write and read ports from the serial decoder
	input  wire rqs_pkg::rqs_wr_t        WR,
	input  wire logic [7:0]              RD_ADDR,
	output logic [7:0]                   RD_DATA,
	// External pins
	input  wire logic                    SYNC_PIN,
	input  wire logic                    MODE_PIN,
	// Clock divider and requantizer controls
	output logic                         DIV_RESET,
	output rqs_pkg::rqs_chan_t [NCHAN-1:0] CHAN_CFG
);
	import rqs_pkg::*;

	logic [7:0]         sync_reg;
	logic [NCHAN-1:0]   chan_idx_reg;
	logic [7:0]         ctrl_reg [NCHAN];
	logic [7:0]         tune_reg [NCHAN];
	logic               sync_s1_reg;
	logic               sync_s2_reg;
	logic               sync_d_reg;
	logic               mode_s1_reg;
	logic               mode_s2_reg;
	logic               armed_reg;
	logic               sync_rise;
	logic               sync_gate;
	logic               sync_fire;
	logic [7:0]         rd_next;
	logic [NCHAN-1:0]   first_sel;

	// Lowest selected channel, used for readback
	function automatic int first_chan(input logic [NCHAN-1:0] sel);
		int k;
		k = 0;
		for (int i = NCHAN - 1; i >= 0; i--)
		begin
			if (sel[i])
				k = i;
		end
		return k;
	endfunction

	// Enable state: pin when pin disable is clear, register bit otherwise
	function automatic logic chan_enable(input logic [7:0] ctrl, input logic pin);
		return ctrl[RQS_CTRL_PINDIS_B] ? ctrl[RQS_CTRL_EN_B] : pin;
	endfunction

	// Two-flop synchronisers for the asynchronous pins
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			sync_s1_reg <= 1'b0;
			sync_s2_reg <= 1'b0;
			sync_d_reg  <= 1'b0;
			mode_s1_reg <= 1'b0;
			mode_s2_reg <= 1'b0;
		end
		else
		begin
			sync_s1_reg <= SYNC_PIN;
			sync_s2_reg <= sync_s1_reg;
			sync_d_reg  <= sync_s2_reg;
			mode_s1_reg <= MODE_PIN;
			mode_s2_reg <= mode_s1_reg;
		end
	end

	// Sync qualification
	assign sync_rise = sync_s2_reg & ~sync_d_reg;
	assign sync_gate = sync_reg[RQS_SYNC_MASTER_B] & sync_reg[RQS_SYNC_DIV_EN_B];
	assign sync_fire = sync_rise & sync_gate
		& (~sync_reg[RQS_SYNC_ONESHOT_B] | armed_reg);

	// Global sync control register; writing it re-arms one-shot mode
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
			sync_reg <= RQS_RST_SYNC;
		else if (WR.wr && WR.addr == RQS_ADDR_SYNC)
			sync_reg <= WR.data & RQS_SYNC_MASK;
	end

	// One-shot arm flag, cleared by the first accepted edge
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
			armed_reg <= 1'b1;
		else if (WR.wr && WR.addr == RQS_ADDR_SYNC)
			armed_reg <= 1'b1;
		else if (sync_fire && sync_reg[RQS_SYNC_ONESHOT_B])
			armed_reg <= 1'b0;
	end

	// Divider reset pulse
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
			DIV_RESET <= 1'b0;
		else
			DIV_RESET <= sync_fire;
	end

	// Channel index register
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
			chan_idx_reg <= NCHAN'(RQS_RST_CHAN_IDX);
		else if (WR.wr && WR.addr == RQS_ADDR_CHAN_IDX)
			chan_idx_reg <= WR.data[NCHAN-1:0];
	end

	// Per-channel registers written only on selected channels
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			for (int i = 0; i < NCHAN; i++)
			begin
				ctrl_reg[i] <= RQS_RST_CTRL;
				tune_reg[i] <= RQS_RST_TUNE;
			end
		end
		else
		begin
			for (int i = 0; i < NCHAN; i++)
			begin
				if (WR.wr && chan_idx_reg[i] && WR.addr == RQS_ADDR_CTRL)
					ctrl_reg[i] <= WR.data & RQS_CTRL_MASK;
				if (WR.wr && chan_idx_reg[i] && WR.addr == RQS_ADDR_TUNE)
					tune_reg[i] <= WR.data & RQS_TUNE_MASK;
			end
		end
	end

	// Channel configuration outputs
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
			CHAN_CFG <= '0;
		else
			for (int i = 0; i < NCHAN; i++)
			begin
				CHAN_CFG[i].enable     <= chan_enable(ctrl_reg[i], mode_s2_reg);
				CHAN_CFG[i].band_width <= ctrl_reg[i][3:1];
				CHAN_CFG[i].tuning     <= tune_reg[i][5:0];
			end
	end

	// Readback mux
	assign first_sel = chan_idx_reg;
	always_comb
	begin
		rd_next = 8'h00;
		case (RD_ADDR)
			RQS_ADDR_CHAN_IDX: rd_next = 8'(chan_idx_reg);
			RQS_ADDR_SYNC:     rd_next = sync_reg;
			RQS_ADDR_CTRL:     rd_next = ctrl_reg[first_chan(first_sel)];
			RQS_ADDR_TUNE:     rd_next = tune_reg[first_chan(first_sel)];
			default:           rd_next = 8'h00;
		endcase
	end

	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
			RD_DATA <= 8'h00;
		else
			RD_DATA <= rd_next;
	end

	// Checks
	sequence s_edge_ok;
		sync_rise && sync_gate && (!sync_reg[RQS_SYNC_ONESHOT_B] || armed_reg);
	endsequence

	chk_div_follow_edge: assert property (@(posedge MCLK) disable iff (!RST_N)
		s_edge_ok |=> DIV_RESET) else $error("Qualified sync edge did not reset divider");
	chk_gate_blocks: assert property (@(posedge MCLK) disable iff (!RST_N)
		DIV_RESET |-> $past(sync_gate)) else $error("Divider reset without sync enables");
	chk_master_off: assert property (@(posedge MCLK) disable iff (!RST_N)
		!sync_reg[RQS_SYNC_MASTER_B] |=> !DIV_RESET) else $error("Sync active with master off");
	chk_oneshot_disarm: assert property (@(posedge MCLK) disable iff (!RST_N)
		(s_edge_ok and (sync_reg[RQS_SYNC_ONESHOT_B] && !WR.wr)) |=> !armed_reg)
		else $error("One-shot not disarmed");
	chk_oneshot_ignore: assert property (@(posedge MCLK) disable iff (!RST_N)
		(sync_reg[RQS_SYNC_ONESHOT_B] && !armed_reg) |=> !DIV_RESET)
		else $error("Edge passed after one-shot");
	chk_pin_follow: assert property (@(posedge MCLK) disable iff (!RST_N)
		!ctrl_reg[0][RQS_CTRL_PINDIS_B] |=> CHAN_CFG[0].enable == $past(mode_s2_reg))
		else $error("Enable not following pin");
	chk_reg_enable: assert property (@(posedge MCLK) disable iff (!RST_N)
		ctrl_reg[0][RQS_CTRL_PINDIS_B] |=> CHAN_CFG[0].enable == $past(ctrl_reg[0][0]))
		else $error("Enable not following register bit");
	chk_unselected_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
		(WR.wr && !chan_idx_reg[1]) |=> $stable(ctrl_reg[1]) && $stable(tune_reg[1]))
		else $error("Unselected channel written");
	chk_band_width: assert property (@(posedge MCLK) disable iff (!RST_N)
		##1 CHAN_CFG[1].band_width == $past(ctrl_reg[1][3:1])) else $error("Band width mismatch");
endmodule

// [verification/rqs_host.sv]
// Host model that writes and reads the control bank
`timescale 1ns/1ns
module rqs_host
	import rqs_pkg::*;
(
	// Clock
	input  wire logic       MCLK,
	// Register port
	output rqs_pkg::rqs_wr_t WR,
	output logic [7:0]      RD_ADDR
);
	import rqs_pkg::*;
	// Port stays quiet until a test needs it
	initial
	begin
		WR      = '0;
		RD_ADDR = 8'h00;
	end
	// One-cycle write strobe, fields cleared afterwards
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge MCLK);
		#1 WR = '{1'b1, a, d};
		@(posedge MCLK);
		#1 WR = '0;
	endtask
	// Read data is registered one edge after the address
	task automatic read_reg(input logic [7:0] a);
		@(posedge MCLK);
		#1 RD_ADDR = a;
		repeat (2) @(posedge MCLK);
		#1;
	endtask
	// Only tuning words inside the mode's legal range
	function automatic logic [5:0] legal_word(input int n);
		return 6'($urandom_range(n - 1));
	endfunction
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the sync and requantizer control bank
`timescale 1ns/1ns
module tb_top;
	import rqs_pkg::*;
	logic            mclk;
	logic            rst_n;
	logic            sync_pin;
	logic            mode_pin;
	rqs_wr_t         wr;
	logic [7:0]      rd_addr;
	logic [7:0]      rd_data;
	logic            div_reset;
	rqs_chan_t [3:0] cfg;
	int              miscompares;
	int              n_compared;
	logic            pulse_q[$];
	logic [5:0]      tw;
	logic [7:0]      sm[5] = '{8'h02, 8'h01, 8'h03, 8'h07, 8'h07};
	int              np[5] = '{0, 0, 3, 1, 1};

	rqs_host host (.MCLK(mclk), .WR(wr), .RD_ADDR(rd_addr));
	rqs_regs #(.NCHAN(4)) dut (.MCLK(mclk), .RST_N(rst_n), .WR(wr), .RD_ADDR(rd_addr),
		.RD_DATA(rd_data), .SYNC_PIN(sync_pin), .MODE_PIN(mode_pin),
		.DIV_RESET(div_reset), .CHAN_CFG(cfg));

	// Clock
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Compare and count
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] s);
		n_compared++;
		if (s !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		host.read_reg(a);
		chk("rd_data", {2'b00, e}, {2'b00, rd_data});
	endtask
	task automatic cfg_chk(input int ch, input logic en, input logic [2:0] band);
		@(posedge mclk);
		#1 chk("chan_cfg", {en, band, 6'h1c}, cfg[ch]);
	endtask
	// Sync pin edges with low gaps, then no pulse may be left owed
	task automatic sync_edges(input int n);
		repeat (n)
		begin
			sync_pin = 1'b1;
			repeat (3) @(posedge mclk);
			#1 sync_pin = 1'b0;
			repeat (3) @(posedge mclk);
			#1;
		end
		repeat (8) @(posedge mclk);
		#1 chk("owed_pulses", 10'h000, 10'(pulse_q.size()));
	endtask
	task automatic finish_test();
		$display("Compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Each divider pulse takes the oldest expected note
	always @(negedge mclk)
		if (rst_n === 1'b1 && div_reset !== 1'b0)
			chk("div_reset", 10'(pulse_q.size() ? pulse_q.pop_front() : 1'b0), 10'(div_reset));
	// Watchdog
	initial
	begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		finish_test();
	end
	// Main sequence
	initial
	begin
		void'($urandom(55));
		rst_n = 1'b0;
		sync_pin = 1'b0;
		mode_pin = 1'b0;
		repeat (12) @(posedge mclk);
		#1 rst_n = 1'b1;
		rd(RQS_ADDR_SYNC, RQS_RST_SYNC);
		rd(RQS_ADDR_CTRL, RQS_RST_CTRL);
		rd(RQS_ADDR_TUNE, RQS_RST_TUNE);
		rd(8'h40, 8'h00);
		cfg_chk(3, 1'b0, RQS_BAND_WIDTH_22);
		mode_pin = 1'b1;
		repeat (4) @(posedge mclk);
		cfg_chk(1, 1'b1, RQS_BAND_WIDTH_22);
		mode_pin = 1'b0;
		host.write_reg(RQS_ADDR_CTRL, 8'h01);
		repeat (4) @(posedge mclk);
		cfg_chk(0, 1'b0, RQS_BAND_WIDTH_22);
		mode_pin = 1'b1;
		host.write_reg(RQS_ADDR_CTRL, 8'h10);
		cfg_chk(0, 1'b0, RQS_BAND_WIDTH_22);
		for (int m = 0; m < 3; m++)
		begin
			host.write_reg(RQS_ADDR_CTRL, {4'h1, 3'(m), 1'b1});
			cfg_chk(2, 1'b1, 3'(m));
		end
		host.write_reg(RQS_ADDR_CTRL, 8'hf5);
		rd(RQS_ADDR_CTRL, 8'h15);
		host.write_reg(RQS_ADDR_CHAN_IDX, 8'h05);
		tw = host.legal_word(57);
		host.write_reg(RQS_ADDR_TUNE, {2'b11, tw});
		rd(RQS_ADDR_TUNE, {2'b00, tw});
		for (int c = 0; c < 4; c++)
			chk("tuning", 10'(c % 2 ? 6'h1c : tw), 10'(cfg[c].tuning));
		for (int i = 0; i < 5; i++)
		begin
			host.write_reg(RQS_ADDR_SYNC, sm[i]);
			repeat (np[i]) pulse_q.push_back(1'b1);
			sync_edges(3);
		end
		finish_test();
	end
endmodule
